// ---- design/serial_boot_loader.sv ----
`timescale 1ns/1ns
`include "boot_loader_regs.svh"
module serial_boot_loader #(
  parameter int CNT_W   = 16,
  parameter int F_DEPTH = 16
) (
  // clock, reset, enable
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       clk_en_i,
  // mode pins
  input  wire logic                       mode_select_pin_high_i,
  input  wire logic                       mode_select_pin_mid_i,
  input  wire logic                       mode_select_pin_low_i,
  // serial channel one
  input  wire logic                       rxd_i,
  output logic                            txd_o,
  // loader status
  input  wire logic                       flash_erased_i,
  input  wire logic                       load_done_i,
  output logic                            boot_active_o,
  output logic                            rate_locked_o,
  output logic [CNT_W-1:0]                bit_cycles_o,
  output logic                            program_start_o,
  // received bytes towards RAM
  output logic                            ram_valid_o,
  output logic [7:0]                      ram_data_o,
  input  wire logic                       ram_ready_i,
  output logic                            rx_unit_done_o,
  output logic                            rx_overrun_o,
  // responses to host
  input  wire logic                       resp_start_i,
  input  wire boot_loader_pkg::resp_kind_t resp_kind_i,
  input  wire logic [7:0]                 resp_len_i,
  input  wire logic                       resp_valid_i,
  input  wire logic [7:0]                 resp_data_i,
  output logic                            resp_ready_o,
  output logic                            frame_done_o
);
  import boot_loader_pkg::*;

  default clocking dflt @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  boot_state_t      state_q, state_d;
  logic [2:0]       pins;
  logic [7:0]       settle_q, settle_d;
  logic [3:0]       sub_q, sub_d;
  logic [CNT_W-1:0] quot_q, quot_d, bit_q, bit_d;
  logic             lock_q, lock_d, start_q, start_d, ack_go;
  logic             active_q, active_d;
  // receiver
  logic             rx_busy_q, rx_busy_d, rx_vld_q, rx_vld_d, rx_en;
  logic [3:0]       rx_idx_q, rx_idx_d;
  logic [CNT_W-1:0] rx_cnt_q, rx_cnt_d;
  logic [7:0]       rx_sh_q, rx_sh_d, rx_byte_q, rx_byte_d;
  // transmitter
  logic             tx_busy_q, tx_busy_d, tx_line_q, tx_line_d, tx_go;
  logic [3:0]       tx_idx_q, tx_idx_d;
  logic [CNT_W-1:0] tx_cnt_q, tx_cnt_d;
  logic [9:0]       tx_sh_q, tx_sh_d;
  logic [7:0]       tx_byte;
  // framing and data path
  logic [7:0]       left_q, left_d, unit_q, unit_d;
  logic             rdy_q, rdy_d, fdone_q, fdone_d, udone_q, udone_d;
  logic             ovr_q, ovr_d, rv_q, rv_d, f_in_v, f_in_r, f_out_v, f_out_r;
  logic [7:0]       rd_q, rd_d, f_out_d;

  assign pins = {mode_select_pin_high_i, mode_select_pin_mid_i, mode_select_pin_low_i};

  // boot control and rate measurement
  always_comb
  begin
    state_d  = state_q;
    settle_d = settle_q;
    sub_d    = sub_q;
    quot_d   = quot_q;
    bit_d    = bit_q;
    lock_d   = lock_q;
    start_d  = start_q;
    ack_go   = 1'b0;
    unique case (state_q)
      ST_OFF:
      begin
        // pins caught on first enabled edge after release
        if (settle_q == '0 && pins == `BOOT_MODE_PINS)
          state_d = ST_SETTLE;
        settle_d = 8'h01;
      end
      ST_SETTLE:
      begin
        settle_d = settle_q + 8'h01;
        if (settle_q == `SETTLE_STATES)
          state_d = ST_WAIT_LOW;
      end
      ST_WAIT_LOW:
      begin
        sub_d  = '0;
        quot_d = '0;
        // line idles high from reset on, so first low is a start bit
        if (!rxd_i)
        begin
          state_d = ST_MEASURE;
          sub_d   = 4'h1;
        end
      end
      ST_MEASURE:
      begin
        if (!rxd_i)
        begin
          // low time divided by nine on the fly
          sub_d = sub_q + 4'h1;
          if (sub_q == `ZERO_BYTE_BITS - 4'h1)
          begin
            sub_d  = '0;
            quot_d = quot_q + 1'b1;
          end
        end
        else if (quot_q != '0)
        begin
          bit_d   = quot_q;
          lock_d  = 1'b1;
          state_d = ST_SEND_ACK;
        end
        else
          state_d = ST_WAIT_LOW;
      end
      ST_SEND_ACK:
      begin
        if (!tx_busy_q)
        begin
          ack_go  = 1'b1;
          state_d = ST_WAIT_CONFIRM;
        end
      end
      ST_WAIT_CONFIRM:
      begin
        if (rx_vld_q && rx_byte_q == `CONFIRM_BYTE)
          state_d = ST_RUN;
      end
      ST_RUN:
      begin
        if (load_done_i && flash_erased_i)
        begin
          start_d = 1'b1;
          state_d = ST_BRANCH;
        end
      end
      ST_BRANCH: start_d = 1'b1;
    endcase
    active_d = (state_d != ST_OFF);
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q  <= ST_OFF;
      settle_q <= '0;
      sub_q    <= '0;
      quot_q   <= '0;
      bit_q    <= '0;
      lock_q   <= 1'b0;
      start_q  <= 1'b0;
      active_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      state_q  <= state_d;
      settle_q <= settle_d;
      sub_q    <= sub_d;
      quot_q   <= quot_d;
      bit_q    <= bit_d;
      lock_q   <= lock_d;
      start_q  <= start_d;
      active_q <= active_d;
    end
  end

  // receiver, sampled mid bit
  assign rx_en = (state_q == ST_WAIT_CONFIRM) || (state_q == ST_RUN);

  always_comb
  begin
    rx_busy_d = rx_busy_q;
    rx_idx_d  = rx_idx_q;
    rx_cnt_d  = rx_cnt_q;
    rx_sh_d   = rx_sh_q;
    rx_byte_d = rx_byte_q;
    rx_vld_d  = 1'b0;
    if (!rx_busy_q)
    begin
      if (rx_en && !rxd_i)
      begin
        rx_busy_d = 1'b1;
        rx_idx_d  = '0;
        rx_cnt_d  = bit_q >> 1;
      end
    end
    else if (rx_cnt_q != '0)
      rx_cnt_d = rx_cnt_q - 1'b1;
    else
    begin
      rx_cnt_d = bit_q - 1'b1;
      rx_idx_d = rx_idx_q + 4'h1;
      if (rx_idx_q == '0 && rxd_i)
        rx_busy_d = 1'b0;
      else if (rx_idx_q == `UART_STOP_IDX)
      begin
        rx_busy_d = 1'b0;
        rx_vld_d  = rxd_i;
        rx_byte_d = rx_sh_q;
      end
      else if (rx_idx_q != '0)
        rx_sh_d = {rxd_i, rx_sh_q[7:1]};
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_busy_q <= 1'b0;
      rx_idx_q  <= '0;
      rx_cnt_q  <= '0;
      rx_sh_q   <= '0;
      rx_byte_q <= '0;
      rx_vld_q  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      rx_busy_q <= rx_busy_d;
      rx_idx_q  <= rx_idx_d;
      rx_cnt_q  <= rx_cnt_d;
      rx_sh_q   <= rx_sh_d;
      rx_byte_q <= rx_byte_d;
      rx_vld_q  <= rx_vld_d;
    end
  end

  // transmitter
  assign tx_go   = ack_go || (resp_valid_i && rdy_q);
  assign tx_byte = ack_go ? `ADJUST_DONE_BYTE : resp_data_i;

  always_comb
  begin
    tx_busy_d = tx_busy_q;
    tx_idx_d  = tx_idx_q;
    tx_cnt_d  = tx_cnt_q;
    tx_sh_d   = tx_sh_q;
    tx_line_d = tx_line_q;
    if (!tx_busy_q)
    begin
      tx_line_d = 1'b1;
      if (tx_go)
      begin
        tx_busy_d = 1'b1;
        tx_sh_d   = {1'b1, tx_byte, 1'b0};
        tx_idx_d  = '0;
        tx_cnt_d  = bit_q - 1'b1;
        tx_line_d = 1'b0;
      end
    end
    else if (tx_cnt_q != '0)
      tx_cnt_d = tx_cnt_q - 1'b1;
    else if (tx_idx_q == `UART_STOP_IDX)
      tx_busy_d = 1'b0;
    else
    begin
      tx_idx_d  = tx_idx_q + 4'h1;
      tx_sh_d   = tx_sh_q >> 1;
      tx_line_d = tx_sh_q[1];
      tx_cnt_d  = bit_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_busy_q <= 1'b0;
      tx_idx_q  <= '0;
      tx_cnt_q  <= '0;
      tx_sh_q   <= '0;
      tx_line_q <= 1'b1;
    end
    else if (clk_en_i)
    begin
      tx_busy_q <= tx_busy_d;
      tx_idx_q  <= tx_idx_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_sh_q   <= tx_sh_d;
      tx_line_q <= tx_line_d;
    end
  end

  // response framing, unit counting and RAM stream
  assign f_in_v  = rx_vld_q && state_q == ST_RUN;
  assign f_out_r = !rv_q || ram_ready_i;

  always_comb
  begin
    left_d  = left_q;
    fdone_d = 1'b0;
    if (state_q == ST_RUN && resp_start_i && left_q == '0)
    begin
      unique case (resp_kind_i)
        RESP_SINGLE: left_d = `SINGLE_RESP_BYTES;
        RESP_MULTI:  left_d = resp_len_i;
        RESP_ERROR:  left_d = `ERROR_RESP_BYTES;
        RESP_READ:   left_d = `READ_RESP_BYTES;
      endcase
    end
    else if (resp_valid_i && rdy_q)
    begin
      left_d  = left_q - 8'h01;
      fdone_d = (left_q == 8'h01);
    end
    rdy_d   = state_q == ST_RUN && left_d != '0 && !tx_busy_d;
    unit_d  = unit_q;
    udone_d = 1'b0;
    ovr_d   = ovr_q || (f_in_v && !f_in_r);
    if (f_in_v && f_in_r)
    begin
      unit_d  = unit_q + 8'h01;
      udone_d = (unit_q == `PROG_UNIT_BYTES - 8'h01);
      if (udone_d)
        unit_d = '0;
    end
    rv_d = rv_q;
    rd_d = rd_q;
    if (f_out_r)
    begin
      rv_d = f_out_v;
      // keep last byte once drained, no unknowns on the data port
      if (f_out_v)
        rd_d = f_out_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      left_q  <= '0;
      fdone_q <= 1'b0;
      rdy_q   <= 1'b0;
      unit_q  <= '0;
      udone_q <= 1'b0;
      ovr_q   <= 1'b0;
      rv_q    <= 1'b0;
      rd_q    <= '0;
    end
    else if (clk_en_i)
    begin
      left_q  <= left_d;
      fdone_q <= fdone_d;
      rdy_q   <= rdy_d;
      unit_q  <= unit_d;
      udone_q <= udone_d;
      ovr_q   <= ovr_d;
      rv_q    <= rv_d;
      rd_q    <= rd_d;
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(F_DEPTH)) byte_fifo_i (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .clk_en_i    (clk_en_i),
    .in_valid_i  (f_in_v),
    .in_ready_o  (f_in_r),
    .in_data_i   (rx_byte_q),
    .out_valid_o (f_out_v),
    .out_ready_i (f_out_r),
    .out_data_o  (f_out_d)
  );

  assign txd_o           = tx_line_q;
  assign boot_active_o   = active_q;
  assign rate_locked_o   = lock_q;
  assign bit_cycles_o    = bit_q;
  assign program_start_o = start_q;
  assign ram_valid_o     = rv_q;
  assign ram_data_o      = rd_q;
  assign rx_unit_done_o  = udone_q;
  assign rx_overrun_o    = ovr_q;
  assign resp_ready_o    = rdy_q;
  assign frame_done_o    = fdone_q;

  AST_BOOT_PINS: assert property (
    state_q == ST_OFF && settle_q == '0 && clk_en_i && pins != `BOOT_MODE_PINS
    |=> state_q == ST_OFF [*2])
    else $error("boot entered with wrong mode pins");
  AST_SETTLE: assert property (
    $rose(state_q == ST_WAIT_LOW) |-> $past(settle_q) == `SETTLE_STATES)
    else $error("measurement armed before settle time");
  AST_RATE: assert property (
    $rose(lock_q) |-> bit_q == $past(quot_q) && bit_q != '0)
    else $error("bit rate not taken from measurement");
  AST_NINTHS: assert property (
    state_q == ST_MEASURE && clk_en_i && !rxd_i && sub_q == `ZERO_BYTE_BITS - 4'h1
    |=> sub_q == '0 && quot_q == $past(quot_q) + 1'b1)
    else $error("low time not divided by nine");
  AST_ONE_ACK: assert property (
    state_q == ST_SEND_ACK && !tx_busy_q && clk_en_i
    |=> tx_busy_q && tx_sh_q == {1'b1, `ADJUST_DONE_BYTE, 1'b0} && state_q == ST_WAIT_CONFIRM)
    else $error("adjustment byte not sent once as zero");
  AST_CONFIRM: assert property (
    $rose(state_q == ST_RUN) |-> $past(rx_vld_q) && $past(rx_byte_q) == `CONFIRM_BYTE)
    else $error("command phase entered without confirmation");
  AST_IGNORE: assert property (
    state_q != ST_RUN && state_q != ST_BRANCH |-> unit_q == '0 && !rv_q)
    else $error("byte accepted before confirmation");
  AST_BRANCH: assert property (
    $rose(start_q) |-> $past(flash_erased_i) && $past(load_done_i))
    else $error("branch before flash erased");
  AST_ERR_LEN: assert property (
    state_q == ST_RUN && resp_start_i && resp_kind_i == RESP_ERROR && left_q == '0
    && clk_en_i |=> left_q == `ERROR_RESP_BYTES)
    else $error("error reply is not two bytes");
  AST_READ_LEN: assert property (
    state_q == ST_RUN && resp_start_i && resp_kind_i == RESP_READ && left_q == '0
    && clk_en_i |=> left_q == `READ_RESP_BYTES)
    else $error("read reply is not four bytes");
  AST_UNIT: assert property (
    $rose(udone_q) |-> unit_q == '0 && $past(unit_q) == `PROG_UNIT_BYTES - 8'h01)
    else $error("unit end not after 128 bytes");

endmodule : serial_boot_loader

// ---- design/boot_loader_regs.svh ----
`ifndef BOOT_LOADER_REGS_SVH
`define BOOT_LOADER_REGS_SVH

// mode pins high, mid, low that select boot mode
`define BOOT_MODE_PINS    3'h3
// cycles after reset before the low period may be measured
`define SETTLE_STATES     8'h64
// bits seen low in one zero byte: start plus eight data
`define ZERO_BYTE_BITS    4'h9
`define ADJUST_DONE_BYTE  8'h00
`define CONFIRM_BYTE      8'h55
// frame index of the stop bit: start, 8 data, 1 stop
`define UART_STOP_IDX     4'h9
`define PROG_UNIT_BYTES   8'h80
`define SINGLE_RESP_BYTES 8'h01
`define ERROR_RESP_BYTES  8'h02
`define READ_RESP_BYTES   8'h04

`endif

// ---- design/boot_loader_pkg.sv ----
package boot_loader_pkg;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_SETTLE,
    ST_WAIT_LOW,
    ST_MEASURE,
    ST_SEND_ACK,
    ST_WAIT_CONFIRM,
    ST_RUN,
    ST_BRANCH
  } boot_state_t;

  typedef enum logic [1:0] {
    RESP_SINGLE,
    RESP_MULTI,
    RESP_ERROR,
    RESP_READ
  } resp_kind_t;

endpackage : boot_loader_pkg

// ---- design/byte_fifo.sv ----
`timescale 1ns/1ns
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             clk_en_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];

  always_comb
  begin
    push = in_valid_i && in_ready_o;
    pop  = out_valid_o && out_ready_i;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else if (clk_en_i)
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (clk_en_i && push)
      mem_q[wr_q] <= in_data_i;
  end

endmodule : byte_fifo

// ---- testbench/host_uart_model.sv ----
`timescale 1ns/1ns
module host_uart_model #(
  parameter int BIT_LEN = 16
) (
  // clock
  input  wire logic core_clk_i,
  // serial lines
  input  wire logic txd_i,
  output logic      rxd_o
);
  // line idle high, also across reset release
  initial rxd_o = 1'b1;

  // start, eight data bits lsb first, one stop, no parity
  task automatic send_byte(input logic [7:0] value);
    logic [9:0] frame;
    frame = {1'b1, value, 1'b0};
    for (int b = 0; b < 10; b++)
    begin
      @(posedge core_clk_i);
      rxd_o <= frame[b];
      repeat (BIT_LEN - 1) @(posedge core_clk_i);
    end
  endtask : send_byte

  task automatic hold_low(input int n);
    @(posedge core_clk_i);
    rxd_o <= 1'b0;
    repeat (n) @(posedge core_clk_i);
    rxd_o <= 1'b1;
  endtask : hold_low

  // samples mid bit on falling edges, away from txd updates
  task automatic recv_byte(output logic [7:0] value, output logic ok);
    int guard;
    guard = 0;
    value = 8'h00;
    while (txd_i !== 1'b0 && guard < 4000)
    begin
      @(negedge core_clk_i);
      guard++;
    end
    ok = (guard < 4000);
    repeat (BIT_LEN / 2) @(negedge core_clk_i);
    ok &= (txd_i === 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_LEN) @(negedge core_clk_i);
      value[i] = txd_i;
    end
    repeat (BIT_LEN) @(negedge core_clk_i);
    ok &= (txd_i === 1'b1);
  endtask : recv_byte
endmodule : host_uart_model

// ---- testbench/serial_boot_loader_protocol_tb.sv ----
`timescale 1ns/1ns
`include "boot_loader_regs.svh"
module serial_boot_loader_protocol_tb;
  import boot_loader_pkg::*;
  localparam int BIT = 16;
  logic        core_clk_i;
  logic        rst_i;
  logic        clk_en_i;
  logic [2:0]  mode_pins;
  logic        rxd;
  logic        txd_o;
  logic        flash_erased_i;
  logic        load_done_i;
  logic        boot_active_o;
  logic        rate_locked_o;
  logic [15:0] bit_cycles_o;
  logic        program_start_o;
  logic        ram_valid_o;
  logic [7:0]  ram_data_o;
  logic        ram_ready_i;
  logic        rx_unit_done_o;
  logic        rx_overrun_o;
  logic        resp_start_i;
  resp_kind_t  resp_kind_i;
  logic [7:0]  resp_len_i;
  logic        resp_valid_i;
  logic [7:0]  resp_data_i;
  logic        resp_ready_o;
  logic        frame_done_o;
  int          miscompares;
  int          samples_checked;
  int          unit_count;
  int          frame_count;

  serial_boot_loader #(.CNT_W(16), .F_DEPTH(16)) serial_boot_loader_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
    .mode_select_pin_high_i(mode_pins[2]), .mode_select_pin_mid_i(mode_pins[1]),
    .mode_select_pin_low_i(mode_pins[0]), .rxd_i(rxd), .txd_o(txd_o),
    .flash_erased_i(flash_erased_i), .load_done_i(load_done_i),
    .boot_active_o(boot_active_o), .rate_locked_o(rate_locked_o),
    .bit_cycles_o(bit_cycles_o), .program_start_o(program_start_o),
    .ram_valid_o(ram_valid_o), .ram_data_o(ram_data_o), .ram_ready_i(ram_ready_i),
    .rx_unit_done_o(rx_unit_done_o), .rx_overrun_o(rx_overrun_o),
    .resp_start_i(resp_start_i), .resp_kind_i(resp_kind_i), .resp_len_i(resp_len_i),
    .resp_valid_i(resp_valid_i), .resp_data_i(resp_data_i),
    .resp_ready_o(resp_ready_o), .frame_done_o(frame_done_o));

  host_uart_model #(.BIT_LEN(BIT)) host_uart_model_i (
    .core_clk_i(core_clk_i), .txd_i(txd_o), .rxd_o(rxd));

  initial
  begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // pulse counters, sampled away from the launching edge
  always @(negedge core_clk_i)
  begin
    if (rx_unit_done_o === 1'b1) unit_count++;
    if (frame_done_o === 1'b1) frame_count++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    samples_checked++;
    if (seen !== expected)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, expected);
    end
  endtask : check

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : wait_n

  task automatic idle_check(input int n, output logic quiet);
    quiet = 1'b1;
    repeat (n)
    begin
      @(negedge core_clk_i);
      quiet &= (txd_o === 1'b1);
    end
  endtask : idle_check

  // host restarts the whole boot sequence by reset
  task automatic do_reset(input logic [2:0] pins);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    mode_pins <= pins;
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
  endtask : do_reset

  task automatic t_lock;
    logic [7:0] v;
    logic       ok;
    wait_n(30);
    host_uart_model_i.hold_low(20);
    wait_n(10);
    check(rate_locked_o, 1'b0);
    wait_n(50);
    fork
      host_uart_model_i.send_byte(8'h00);
      host_uart_model_i.recv_byte(v, ok);
    join
    check(rate_locked_o, 1'b1);
    check(bit_cycles_o, BIT);
    check(v, `ADJUST_DONE_BYTE);
    check(ok, 1'b1);
    idle_check(12 * BIT, ok);
    check(ok, 1'b1);
    host_uart_model_i.send_byte(8'h12);
    wait_n(2 * BIT);
    check(ram_valid_o, 1'b0);
    host_uart_model_i.send_byte(`CONFIRM_BYTE);
    wait_n(2 * BIT);
  endtask : t_lock

  // sixteen in the fifo plus one in the output register, the 18th drops
  task automatic t_fifo;
    for (int i = 0; i < 18; i++)
    begin
      host_uart_model_i.send_byte(8'h30 + 8'(i));
      wait_n(4);
      check(rx_overrun_o, i == 17);
    end
    for (int i = 0; i < 17; i++)
    begin
      check(ram_valid_o, 1'b1);
      check(ram_data_o, 8'h30 + 8'(i));
      @(posedge core_clk_i);
      ram_ready_i <= 1'b1;
      @(posedge core_clk_i);
      ram_ready_i <= 1'b0;
      wait_n(4);
    end
    check(ram_valid_o, 1'b0);
  endtask : t_fifo

  // seventeen bytes already pushed, so 111 more close the unit
  task automatic t_unit;
    @(posedge core_clk_i);
    ram_ready_i <= 1'b1;
    for (int i = 0; i < 111; i++)
    begin
      host_uart_model_i.send_byte(8'(i));
      wait_n(4);
      check(unit_count, i == 110);
    end
  endtask : t_unit

  task automatic t_resp(input resp_kind_t kind, input logic [7:0] len, input int n);
    int         frames;
    int         g;
    logic [7:0] v;
    logic       ok;
    frames = frame_count;
    check(resp_ready_o, 1'b0);
    fork
      for (int i = 0; i < n; i++)
      begin
        host_uart_model_i.recv_byte(v, ok);
        check(v, 8'ha0 + 8'(i));
        check(ok, 1'b1);
      end
      begin
        @(posedge core_clk_i);
        resp_start_i <= 1'b1;
        resp_kind_i <= kind;
        resp_len_i <= len;
        @(posedge core_clk_i);
        resp_start_i <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
          resp_valid_i <= 1'b1;
          resp_data_i <= 8'ha0 + 8'(i);
          g = 0;
          do
          begin
            @(negedge core_clk_i);
            g++;
          end
          while (resp_ready_o !== 1'b1 && g < 4000);
          @(posedge core_clk_i);
        end
        resp_valid_i <= 1'b0;
      end
    join
    idle_check(12 * BIT, ok);
    check(ok, 1'b1);
    check(frame_count - frames, 1);
  endtask : t_resp

  task automatic t_branch;
    @(posedge core_clk_i);
    load_done_i <= 1'b1;
    wait_n(10);
    check(program_start_o, 1'b0);
    @(posedge core_clk_i);
    flash_erased_i <= 1'b1;
    clk_en_i <= 1'b0;
    wait_n(5);
    check(program_start_o, 1'b0);
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    wait_n(3);
    check(program_start_o, 1'b1);
  endtask : t_branch

  task automatic t_modes;
    for (int m = 0; m < 8; m++)
    begin
      do_reset(3'(m));
      wait_n(4);
      check(boot_active_o, m == 3);
    end
  endtask : t_modes

  // roughly four times the expected run
  initial
  begin
    #2000000;
    miscompares++;
    final_report();
  end

  initial
  begin
    rst_i = 1'b1;
    clk_en_i = 1'b1;
    mode_pins = 3'h3;
    flash_erased_i = 1'b0;
    load_done_i = 1'b0;
    ram_ready_i = 1'b0;
    resp_start_i = 1'b0;
    resp_kind_i = RESP_SINGLE;
    resp_len_i = 8'h00;
    resp_valid_i = 1'b0;
    resp_data_i = 8'h00;
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    wait_n(4);
    check(boot_active_o, 1'b1);
    t_lock();
    t_fifo();
    t_unit();
    t_resp(RESP_SINGLE, 8'h07, 1);
    t_resp(RESP_MULTI, 8'h03, 3);
    t_resp(RESP_ERROR, 8'h00, 2);
    t_resp(RESP_READ, 8'h00, 4);
    t_branch();
    t_modes();
    final_report();
  end
endmodule : serial_boot_loader_protocol_tb
